// ==== hw/adctp_pkg.sv ====
// Constants, register map and state type of the output test pattern generator.
// Assumes one clock domain (hclk) and an AHB-Lite master with word accesses only.
package adctp_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  // Control fields
  localparam int CTRL_PTN = 0;
  localparam int CTRL_DEMUX = 1;
  localparam int CTRL_DDR = 2;
  localparam int CTRL_EDGE = 3;
  localparam int CTRL_ILV = 4;
  localparam logic [4:0] CTRL_RESET = 5'h02;
  // Status fields
  localparam int ST_REALIGN = 0;
  localparam int ST_RUN = 1;
  localparam int ST_OOR = 2;
  localparam int ST_LAG = 3;
  ////////////////////////////////////////////////////////////////////////////////
  // Pattern words
  localparam logic [7:0] BASE_QD = 8'h01;
  localparam logic [7:0] BASE_ID = 8'h02;
  localparam logic [7:0] BASE_Q_DMX = 8'h03;
  localparam logic [7:0] BASE_I_DMX = 8'h04;
  localparam logic [7:0] BASE_Q_NDX = 8'h01;
  localparam logic [7:0] BASE_I_NDX = 8'h02;
  localparam logic [7:0] IDLE_WORD = 8'h00;
  localparam logic [7:0] CLIP_HIGH = 8'hff;
  localparam logic [7:0] CLIP_LOW = 8'h00;
  // Bit n set: slot n carries the complement
  localparam logic [4:0] COMP_MASK_DMX = 5'b01010;
  localparam logic [9:0] COMP_MASK_NDX = 10'b0100110010;
  localparam logic [3:0] SLOTS_DMX = 4'h5;
  localparam logic [3:0] SLOTS_NDX = 4'ha;
  ////////////////////////////////////////////////////////////////////////////////
  // Timing, in sample (hclk) cycles
  localparam logic [2:0] RESUME_DMX0 = 3'h4;
  localparam logic [2:0] RESUME_OTHER = 3'h3;
  localparam logic [1:0] HALF_DMX = 2'h2;
  localparam logic [1:0] HALF_NDX = 2'h1;
  ////////////////////////////////////////////////////////////////////////////////
  // Whole state of the block
  typedef struct packed {
    logic [4:0] ctrl;
    logic [31:0] rdata;
    logic rdy;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [2:0] sync;
    logic realign;
    logic [2:0] resume;
    logic run;
    logic [1:0] half;
    logic clk_out;
    logic [3:0] slot;
    logic [3:0] prev_slot;
    logic lag;
    logic [7:0] qd;
    logic [7:0] id;
    logic [7:0] q;
    logic [7:0] i;
    logic oor;
  } adctp_state_t;
endpackage

// ==== hw/adctp_top.sv ====
// Output test pattern generator with clipping of normal conversions.
// Assumes hclk is the sample clock and the realign pulse is asynchronous.
// What this block does
// [R1] Demux mode: four ports, five-slot alternating words
// [R2] Non-demux mode: Q/I ports, ten-slot word order
// [R3] Unaligned start: I side lags one slot
// [R4] Controller holds realign while enabling pattern
// [R5] Pattern starts at release, first slot everywhere
// [R6] Full rate in SDR, DDR, demux, interleave
// [R7] Clip over-range samples, flag while out
// [R8] Pattern replaces converter on all ports, flag
// [R9] Clock resumes four or three cycles later
// [R10] Clock held fixed while realign asserted
// [R11] Slot counter cleared while realign asserted
module adctp_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic out_clk_realign_pulse,
  input wire logic [9:0] conv_q,
  input wire logic [9:0] conv_i,
  output logic [7:0] q_delayed_port,
  output logic [7:0] i_delayed_port,
  output logic [7:0] q_port,
  output logic [7:0] i_port,
  output logic out_of_range,
  output logic forwarded_output_clock
);
  adctp_pkg::adctp_state_t st_q; // Registered state
  adctp_pkg::adctp_state_t st_d; // Next state
  logic adv_w; // Output word advances this cycle
  logic comp_w; // Current slot is a complement slot
  logic pcomp_w; // Previous slot is a complement slot
  logic dmx_w; // Demux mode selected
  logic ptn_w; // Pattern selected

  ////////////////////////////////////////////////////////////////////////////////
  // Complement flag of a slot in the active order
  function automatic logic pat_comp(input logic [3:0] s, input logic dmx);
    logic r;
    r = 1'b0;
    if (dmx) begin
      if (s < adctp_pkg::SLOTS_DMX) begin
        r = adctp_pkg::COMP_MASK_DMX[s[2:0]];
      end
    end else if (s < adctp_pkg::SLOTS_NDX) begin
      r = adctp_pkg::COMP_MASK_NDX[s];
    end
    return r;
  endfunction

  // Clip a signed conversion to 00h..FFh, flag in bit 8
  function automatic logic [8:0] clip(input logic [9:0] c);
    logic [8:0] r;
    r = {1'b0, c[7:0]};
    if (c[9]) begin
      r = {1'b1, adctp_pkg::CLIP_LOW};
    end else if (c[8]) begin
      r = {1'b1, adctp_pkg::CLIP_HIGH};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, realign sync, clock and pattern
  always_comb begin
    logic [3:0] period;
    logic [1:0] half_len;
    logic [8:0] cq;
    logic [8:0] ci;
    logic [7:0] mq;
    logic [7:0] mi;
    st_d = st_q;
    dmx_w = st_q.ctrl[adctp_pkg::CTRL_DEMUX];
    ptn_w = st_q.ctrl[adctp_pkg::CTRL_PTN];
    period = dmx_w ? adctp_pkg::SLOTS_DMX : adctp_pkg::SLOTS_NDX;
    half_len = dmx_w ? adctp_pkg::HALF_DMX : adctp_pkg::HALF_NDX;
    comp_w = pat_comp(st_q.slot, dmx_w);
    pcomp_w = pat_comp(st_q.prev_slot, dmx_w);
    adv_w = 1'b0;
    cq = clip(conv_q);
    ci = clip(conv_i);
    mq = {8{comp_w}};
    mi = {8{st_q.lag ? pcomp_w : comp_w}};
    st_d.rdy = 1'b1;
    // Data phase of a write updates the control register
    st_d.wr_pend = 1'b0;
    if (st_q.wr_pend && st_q.wr_addr == adctp_pkg::ADDR_CTRL) begin
      st_d.ctrl = hwdata[4:0];
      // Enabling without realign leaves the I side one slot behind
      if (!ptn_w && hwdata[adctp_pkg::CTRL_PTN] && !st_q.realign) begin
        st_d.lag = 1'b1; // R3
      end
    end
    // Address phase: latch writes, answer reads with zero wait
    st_d.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        st_d.wr_pend = 1'b1;
        st_d.wr_addr = haddr[7:0];
      end else if (haddr[7:0] == adctp_pkg::ADDR_CTRL) begin
        st_d.rdata = {27'h0, st_q.ctrl};
      end else if (haddr[7:0] == adctp_pkg::ADDR_STATUS) begin
        st_d.rdata = {28'h0, st_q.lag, st_q.oor, st_q.run, st_q.realign};
      end
    end
    // Three-stage sync, change taken once stages two and three agree
    st_d.sync = {st_q.sync[1:0], out_clk_realign_pulse}; // R4
    if (st_q.sync[1] == st_q.sync[2]) begin
      st_d.realign = st_q.sync[2];
    end
    if (st_q.realign) begin
      // Hold clock level, clear slots, arm resume delay
      st_d.clk_out = st_q.ctrl[adctp_pkg::CTRL_DDR] ? st_q.ctrl[adctp_pkg::CTRL_EDGE]
                                                     : ~st_q.ctrl[adctp_pkg::CTRL_EDGE]; // R10
      st_d.slot = 4'h0; // R11
      st_d.prev_slot = 4'h0;
      st_d.lag = 1'b0; // R5
      st_d.half = 2'h0;
      st_d.run = 1'b0;
      st_d.resume = (dmx_w && !st_q.ctrl[adctp_pkg::CTRL_DDR]) ? adctp_pkg::RESUME_DMX0
                                                                : adctp_pkg::RESUME_OTHER; // R9
    end else if (st_q.resume != 3'h0) begin
      // Systematic delay before the clock restarts
      st_d.resume = st_q.resume - 3'h1; // R9
      if (st_q.resume == 3'h1) begin
        st_d.run = 1'b1;
      end
    end else if (st_q.run) begin
      // Half-period counter; DDR advances on both edges, SDR on rising
      if (st_q.half + 2'h1 >= half_len) begin
        st_d.half = 2'h0;
        st_d.clk_out = ~st_q.clk_out;
        adv_w = st_q.ctrl[adctp_pkg::CTRL_DDR] || !st_q.clk_out; // R6
      end else begin
        st_d.half = st_q.half + 2'h1;
      end
    end
    if (adv_w) begin
      st_d.prev_slot = st_q.slot;
      st_d.slot = (st_q.slot + 4'h1 >= period) ? 4'h0 : st_q.slot + 4'h1; // R1 R2
      if (ptn_w) begin
        // Pattern drives every port and the flag, converter ignored
        st_d.oor = comp_w; // R8
        if (dmx_w) begin
          st_d.qd = adctp_pkg::BASE_QD ^ mq; // R1
          // Delayed I follows the I side, so the whole I pair lags together
          st_d.id = adctp_pkg::BASE_ID ^ mi; // R3
          st_d.q = adctp_pkg::BASE_Q_DMX ^ mq;
          st_d.i = adctp_pkg::BASE_I_DMX ^ mi; // R3
        end else begin
          st_d.qd = adctp_pkg::IDLE_WORD;
          st_d.id = adctp_pkg::IDLE_WORD;
          st_d.q = adctp_pkg::BASE_Q_NDX ^ mq; // R2
          st_d.i = adctp_pkg::BASE_I_NDX ^ mi;
        end
      end else begin
        // Normal conversion with clipping and range flag
        st_d.oor = cq[8] | ci[8]; // R7
        st_d.q = cq[7:0];
        st_d.i = ci[7:0];
        st_d.qd = dmx_w ? st_q.q : adctp_pkg::IDLE_WORD;
        st_d.id = dmx_w ? st_q.i : adctp_pkg::IDLE_WORD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
      st_q.ctrl <= adctp_pkg::CTRL_RESET;
      st_q.rdy <= 1'b1;
      st_q.run <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register; hresp tied low
  assign hrdata = st_q.rdata;
  assign hreadyout = st_q.rdy;
  assign hresp = 1'b0;
  assign q_delayed_port = st_q.qd;
  assign i_delayed_port = st_q.id;
  assign q_port = st_q.q;
  assign i_port = st_q.i;
  assign out_of_range = st_q.oor;
  assign forwarded_output_clock = st_q.clk_out;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_DMX_BASE: assert property (adv_w && ptn_w && dmx_w && !st_q.lag && !comp_w |=> // R1
    q_delayed_port == 8'h01 && i_delayed_port == 8'h02 && q_port == 8'h03 &&
    i_port == 8'h04 && !out_of_range) else $error("demux base word wrong");
  AST_DMX_COMP: assert property (adv_w && ptn_w && dmx_w && !st_q.lag && comp_w |=> // R1
    q_delayed_port == 8'hfe && i_delayed_port == 8'hfd && q_port == 8'hfc &&
    i_port == 8'hfb && out_of_range) else $error("demux complement word wrong");
  AST_NDX_WORD: assert property (adv_w && ptn_w && !dmx_w && !st_q.lag |=> // R2
    q_port == ($past(comp_w) ? 8'hfe : 8'h01) && i_port == ($past(comp_w) ? 8'hfd : 8'h02))
    else $error("non-demux word wrong");
  AST_SLOT_WRAP: assert property (adv_w && !dmx_w && st_q.slot == 4'h9 |=> // R2
    st_q.slot == 4'h0) else $error("ten-slot order did not wrap");
  AST_LAG_I: assert property (adv_w && ptn_w && dmx_w && st_q.lag |=> // R3
    i_port == (8'h04 ^ {8{$past(pcomp_w)}}) &&
    i_delayed_port == (8'h02 ^ {8{$past(pcomp_w)}})) else $error("lagging I word wrong");
  AST_FIRST_SLOT: assert property ($rose(st_q.run) |-> st_q.slot == 4'h0) // R5
    else $error("pattern did not start at first slot");
  AST_CLIP_HIGH: assert property (adv_w && !ptn_w && !conv_q[9] && conv_q[8] |=> // R7
    q_port == 8'hff && out_of_range) else $error("over-range not clipped");
  AST_PTN_FLAG: assert property (adv_w && ptn_w |=> out_of_range == $past(comp_w)) // R8
    else $error("flag not driven by pattern");
  AST_RESUME4: assert property ($fell(st_q.realign) && dmx_w &&
    !st_q.ctrl[adctp_pkg::CTRL_DDR] |-> !st_q.run [*4] ##1 st_q.run) // R9
    else $error("four-cycle resume wrong");
  AST_RESUME3: assert property ($fell(st_q.realign) &&
    !(dmx_w && !st_q.ctrl[adctp_pkg::CTRL_DDR]) |-> !st_q.run [*3] ##1 st_q.run) // R9
    else $error("three-cycle resume wrong");
  // Held level follows the control word of the previous cycle, as registered
  AST_HOLD_CLK: assert property (st_q.realign ##1 st_q.realign |-> // R10
    forwarded_output_clock == ($past(st_q.ctrl[adctp_pkg::CTRL_DDR]) ?
    $past(st_q.ctrl[adctp_pkg::CTRL_EDGE]) : ~$past(st_q.ctrl[adctp_pkg::CTRL_EDGE])) &&
    st_q.slot == 4'h0) // R11
    else $error("clock or slot not held during realign");
endmodule // adctp_top

// ==== testbench/adctp_capture.sv ====
// Far-side capture logic clocked by the forwarded output clock.
// Assumes data ports settle within 20 ns of a forwarded clock edge.
module adctp_capture (
  input wire logic forwarded_output_clock,
  input wire logic ddr,
  input wire logic [7:0] q_delayed_port,
  input wire logic [7:0] i_delayed_port,
  input wire logic [7:0] q_port,
  input wire logic [7:0] i_port,
  input wire logic out_of_range
);
  timeunit 1ns;
  timeprecision 1ns;
  // Captured words, oldest first: {flag, qd, id, q, i}
  logic [32:0] words[$];
  //////////////////////////////////////////////////////////////////////////////
  // Rising edge in SDR, both edges in DDR; sample once data has settled
  always @(forwarded_output_clock) begin
    if (ddr || forwarded_output_clock) begin
      #20;
      words.push_back({out_of_range, q_delayed_port, i_delayed_port, q_port, i_port});
    end
  end
endmodule // adctp_capture

// ==== testbench/tb.sv ====
// Self-checking bench for the output test pattern generator.
// Assumes a zero-wait AHB-Lite slave and the capture model beside it.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, realign = 0, cap_ddr = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [9:0] conv_q = 0, conv_i = 0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, oor, fclk;
  logic [7:0] qd, id, q, i;
  int fail_count = 0, checked = 0;
  //////////////////////////////////////////////////////////////////////////////
  adctp_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .out_clk_realign_pulse(realign),
    .conv_q(conv_q), .conv_i(conv_i), .q_delayed_port(qd), .i_delayed_port(id),
    .q_port(q), .i_port(i), .out_of_range(oor), .forwarded_output_clock(fclk));
  adctp_capture cap_u (.forwarded_output_clock(fclk), .ddr(cap_ddr), .q_delayed_port(qd),
    .i_delayed_port(id), .q_port(q), .i_port(i), .out_of_range(oor));
  // Sample clock, 25 MHz
  initial begin
    forever #20 hclk = ~hclk;
  end
  // Hang guard
  initial begin
    #2000000;
    fail_count++;
    finish_test();
  end
  //////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One AHB-Lite single word transfer, waiting on hready in both phases
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({32'h0, hresp}, 33'h0);
  endtask
  // Aligned start of a pattern, then ten captured words against the slot table
  task run_pat(input logic [4:0] ctl, input int per, input logic [9:0] mask);
    logic [31:0] base;
    logic comp;
    int n;
    base = ctl[1] ? 32'h01020304 : 32'h00000102;
    cap_ddr <= ctl[2];
    @(posedge hclk) realign <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(1'b1, 8'h00, {27'h0, ctl});
    repeat (3) @(posedge hclk);
    chk({32'h0, fclk}, {32'h0, ctl[2] ? ctl[3] : ~ctl[3]});
    repeat (3) @(posedge hclk);
    chk({32'h0, fclk}, {32'h0, ctl[2] ? ctl[3] : ~ctl[3]});
    // Status during realign: realign seen, clock stopped
    bus(1'b0, 8'h04, 32'h0);
    chk({31'h0, rd[1:0]}, 33'h1);
    cap_u.words.delete();
    realign <= 1'b0;
    n = 0;
    while (cap_u.words.size() < 10 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    chk({32'h0, n < 400}, 33'h1);
    for (int k = 0; k < 10 && k < cap_u.words.size(); k++) begin
      comp = mask[k % per];
      chk(cap_u.words[k], {comp, base ^ (comp ? (ctl[1] ? '1 : 32'hffff) : 32'h0)});
    end
    bus(1'b0, 8'h04, 32'h0);
    chk({32'h0, rd[3]}, 33'h0);
  endtask
  // Normal conversion clipping and range flag
  task clip(input logic [9:0] cq, input logic [9:0] ci, input logic [16:0] exp);
    conv_q <= cq;
    conv_i <= ci;
    repeat (8) @(posedge hclk);
    chk({16'h0, oor, q, i}, {16'h0, exp});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk({1'b0, qd, id, q, i}, 33'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk({1'b0, rd}, 33'h2);
    bus(1'b0, 8'h08, 32'h0);
    chk({1'b0, rd}, 33'h0);
    bus(1'b1, 8'h00, 32'h0);
    clip(10'h12c, 10'h3fb, 17'h1ff00);
    bus(1'b0, 8'h04, 32'h0);
    chk({32'h0, rd[2]}, 33'h1);
    clip(10'h064, 10'h032, 17'h06432);
    clip(10'h3fb, 10'h100, 17'h100ff);
    bus(1'b1, 8'h00, 32'h3);
    repeat (6) @(posedge hclk);
    bus(1'b0, 8'h04, 32'h0);
    chk({32'h0, rd[3]}, 33'h1);
    conv_q <= 10'h12c;
    run_pat(5'h03, 5, 10'b0000001010);
    run_pat(5'h01, 10, 10'b0100110010);
    run_pat(5'h07, 5, 10'b0000001010);
    run_pat(5'h0d, 10, 10'b0100110010);
    run_pat(5'h13, 5, 10'b0000001010);
    finish_test();
  end
endmodule // tb
